// file: rtl/cdce_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef CDCE_MAP_SVH
`define CDCE_MAP_SVH

// register byte offsets on the bus
`define CDCE_SYS_OFS   16'h0100
`define CDCE_DSP_OFS   16'h0120
`define CDCE_IMP_OFS   16'h0130
`define CDCE_STAT_OFS  16'h0134

// field positions inside both clock control registers
`define CDCE_FRAC_BIT  15
`define CDCE_FREQ_HI   10
`define CDCE_FREQ_LO   8
`define CDCE_EN_BIT    6
`define CDCE_SRC_HI    3
`define CDCE_SRC_LO    0

// writable bits and reset values
`define CDCE_SYS_MASK  16'h874f
`define CDCE_DSP_MASK  16'h074f
`define CDCE_SYS_RST   16'h0400
`define CDCE_DSP_RST   16'h0004

// core and processor clock source codes
`define CDCE_SRC_MC1   4'h0
`define CDCE_SRC_MC2   4'h1
`define CDCE_SRC_PLL1  4'h4
`define CDCE_SRC_AOPLL 4'h7
`define CDCE_SRC_IF1   4'h8
`define CDCE_SRC_IF2   4'h9

// number of reference inputs
`define CDCE_NREF      6

// blanking time after a source change, rounded up to whole cycles
`define CDCE_CLK_NS    4
`define CDCE_HOLD_NS   16
`define CDCE_HOLD_CYC  ((`CDCE_HOLD_NS + `CDCE_CLK_NS - 1) / `CDCE_CLK_NS)

// impedance result validity window
`define CDCE_IMP_MIN   10'h0a9
`define CDCE_IMP_MAX   10'h3f9

`endif

// file: rtl/cdce_pkg.sv
// types and source decode shared by the clock control block
`include "cdce_map.svh"
package cdce_pkg;

    // gate controller states
    typedef enum logic [1:0] {
        GATE_OFF,
        GATE_HOLD,
        GATE_RUN
    } cdce_gate_st_t;

    // clock configuration carried out of the block on the cfg outputs; the gates take en and src bits straight from the registers
    typedef struct packed {
        logic       frac;  // fractional frequency family
        logic [2:0] freq;  // frequency code
        logic       en;    // clock enable
        logic [3:0] src;   // source code
    } cdce_clk_cfg_t;

    // decoded source: usable flag and reference index
    typedef struct packed {
        logic       ok;
        logic [2:0] idx;
    } cdce_src_sel_t;

    // maps a source code onto a reference input
    function automatic cdce_src_sel_t cdce_decode_src(input logic [3:0] code);
        cdce_src_sel_t s;
        s = '{ok: 1'b1, idx: 3'h0};
        case (code)
            `CDCE_SRC_MC1:   s.idx = 3'h0;
            `CDCE_SRC_MC2:   s.idx = 3'h1;
            `CDCE_SRC_PLL1:  s.idx = 3'h2;
            `CDCE_SRC_AOPLL: s.idx = 3'h3;
            `CDCE_SRC_IF1:   s.idx = 3'h4;
            `CDCE_SRC_IF2:   s.idx = 3'h5;
            default:         s.ok  = 1'b0;
        endcase
        return s;
    endfunction : cdce_decode_src

endpackage : cdce_pkg

// file: rtl/cdce_ref_sync.sv
// two-flop synchronisers and rising edge detect for reference inputs
`timescale 1ns/1ps
`default_nettype none
`include "cdce_map.svh"
module cdce_ref_sync (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // asynchronous reference levels
    input  wire logic [`CDCE_NREF-1:0] ref_i,
    // one-cycle pulse per rising reference edge
    output logic      [`CDCE_NREF-1:0] rise_o
);

    genvar g;
    generate
        for (g = 0; g < `CDCE_NREF; g++) begin : g_ref
            logic meta_q, meta_d;  // first stage, read only by sync_q
            logic sync_q, sync_d;  // second stage
            logic last_q, last_d;  // previous synced level

            // next values
            always_comb begin
                meta_d = ref_i[g];
                sync_d = meta_q;
                last_d = sync_q;
            end

            // registers
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    last_q <= 1'b0;
                end else begin
                    meta_q <= meta_d;
                    sync_q <= sync_d;
                    last_q <= last_d;
                end
            end

            // edge seen on the synced level only
            assign rise_o[g] = sync_q & ~last_q;
        end
    endgenerate

endmodule : cdce_ref_sync
`default_nettype wire

// file: rtl/cdce_clk_gate.sv
// glitch-free enable gate with source switching for one derived clock
`timescale 1ns/1ps
`default_nettype none
`include "cdce_map.svh"
module cdce_clk_gate (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // configuration
    input  wire logic                  en_i,
    input  wire logic [3:0]            src_i,
    // reference edges
    input  wire logic [`CDCE_NREF-1:0] rise_i,
    // gated tick and state
    output logic                       tick_o,
    output logic                       run_o,
    output logic      [3:0]            act_src_o
);

    cdce_pkg::cdce_gate_st_t st_q, st_d;  // gate state
    logic [2:0]              cnt_q, cnt_d; // blanking counter
    logic [3:0]              act_q, act_d; // source in use
    logic                    tick_q, tick_d;
    logic                    run_q, run_d;
    cdce_pkg::cdce_src_sel_t sel;          // decoded active source

    assign sel = cdce_pkg::cdce_decode_src(act_q);

    // next state: blank the output on enable and source changes
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        act_d  = act_q;
        tick_d = 1'b0;
        case (st_q)
            cdce_pkg::GATE_OFF: begin
                if (en_i) begin
                    act_d = src_i;
                    cnt_d = 3'(`CDCE_HOLD_CYC);
                    st_d  = cdce_pkg::GATE_HOLD;
                end
            end
            cdce_pkg::GATE_HOLD: begin
                if (!en_i) begin
                    st_d = cdce_pkg::GATE_OFF;
                end else if (src_i != act_q) begin
                    act_d = src_i;
                    cnt_d = 3'(`CDCE_HOLD_CYC);
                end else if (cnt_q == 3'h1) begin
                    st_d = cdce_pkg::GATE_RUN;
                end else begin
                    cnt_d = cnt_q - 3'h1;
                end
            end
            cdce_pkg::GATE_RUN: begin
                if (!en_i) begin
                    st_d = cdce_pkg::GATE_OFF;
                end else if (src_i != act_q) begin
                    // switch without dropping the enable
                    act_d = src_i;
                    cnt_d = 3'(`CDCE_HOLD_CYC);
                    st_d  = cdce_pkg::GATE_HOLD;
                end else begin
                    tick_d = sel.ok & rise_i[sel.idx];
                end
            end
            default: st_d = cdce_pkg::GATE_OFF;
        endcase
        run_d = (st_d == cdce_pkg::GATE_RUN);
    end

    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q   <= cdce_pkg::GATE_OFF;
            cnt_q  <= 3'h0;
            act_q  <= 4'h0;
            tick_q <= 1'b0;
            run_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            act_q  <= act_d;
            tick_q <= tick_d;
            run_q  <= run_d;
        end
    end

    assign tick_o    = tick_q;
    assign run_o     = run_q;
    assign act_src_o = act_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_off_no_tick: assert property (!en_i |=> !tick_o)
        else $error("tick after enable cleared");
    a_hold_quiet: assert property ((st_q != cdce_pkg::GATE_RUN) |=> !tick_o)
        else $error("tick while blanked");
    a_switch_blanks: assert property (
        (st_q == cdce_pkg::GATE_RUN && en_i && src_i != act_q)
        |=> (st_q == cdce_pkg::GATE_HOLD) [*4])
        else $error("source switch not blanked four cycles");
    a_reserved_quiet: assert property (!sel.ok |=> !tick_o)
        else $error("tick from reserved source");

endmodule : cdce_clk_gate
`default_nettype wire

// file: rtl/cdce_clock_ctrl.sv
// core and processor clock enable control with wishbone registers
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cdce_map.svh"
module cdce_clock_ctrl (
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // wishbone slave
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic        [15:0]            wb_adr_i,
    input  wire logic        [3:0]             wb_sel_i,
    input  wire logic        [31:0]            wb_dat_i,
    output logic             [31:0]            wb_dat_o,
    output logic                               wb_ack_o,
    // reference clock pins, asynchronous
    input  wire logic        [`CDCE_NREF-1:0]  ref_clk_i,
    // impedance measurement, same clock
    input  wire logic                          impedance_strobe_i,
    input  wire logic        [9:0]             impedance_dac_value_i,
    input  wire logic        [1:0]             impedance_range_indication_i,
    // derived clock ticks and settings
    output logic                               core_clock_o,
    output logic                               processor_clock_o,
    output cdce_pkg::cdce_clk_cfg_t            core_clock_cfg_o,
    output cdce_pkg::cdce_clk_cfg_t            processor_clock_cfg_o,
    // impedance result
    output logic                               impedance_valid_o,
    output logic             [1:0]             impedance_range_o
);

    // register state
    logic [15:0] sys_q, sys_d;    // system_clock_control
    logic [15:0] dsp_q, dsp_d;    // dsp_clock_control
    logic        ack_q, ack_d;    // bus acknowledge
    logic [31:0] rdat_q, rdat_d;  // read data
    logic [9:0]  dac_q, dac_d;    // last dac value
    logic        val_q, val_d;    // result valid
    logic [1:0]  rng_q, rng_d;    // qualified range

    // bus request, one per access
    logic req;
    logic wr;
    logic [`CDCE_NREF-1:0] rise;       // reference edges
    logic                  core_run;   // core gate running
    logic                  proc_run;   // processor gate running
    logic [3:0]            core_act;   // core source in use
    logic [3:0]            proc_act;   // processor source in use
    logic                  in_win;     // dac value inside window

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr  = req & wb_we_i;

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] mask);
        logic [15:0] nv;
        nv[7:0]  = wb_sel_i[0] ? wb_dat_i[7:0]  : old[7:0];
        nv[15:8] = wb_sel_i[1] ? wb_dat_i[15:8] : old[15:8];
        return nv & mask;
    endfunction : merge16

    // unpack a control register into the carrier
    function automatic cdce_pkg::cdce_clk_cfg_t to_cfg(input logic [15:0] r);
        cdce_pkg::cdce_clk_cfg_t c;
        c.frac = r[`CDCE_FRAC_BIT];
        c.freq = r[`CDCE_FREQ_HI:`CDCE_FREQ_LO];
        c.en   = r[`CDCE_EN_BIT];
        c.src  = r[`CDCE_SRC_HI:`CDCE_SRC_LO];
        return c;
    endfunction : to_cfg

    // register writes: source, frequency and enable land together
    always_comb begin
        sys_d = sys_q;
        dsp_d = dsp_q;
        if (wr) begin
            case (wb_adr_i)
                `CDCE_SYS_OFS: sys_d = merge16(sys_q, `CDCE_SYS_MASK);
                `CDCE_DSP_OFS: dsp_d = merge16(dsp_q, `CDCE_DSP_MASK);
                default: ;
            endcase
        end
    end

    // read mux and acknowledge; unmapped reads return zero
    always_comb begin
        ack_d  = req;
        rdat_d = 32'h0000_0000;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                `CDCE_SYS_OFS:  rdat_d = {16'h0000, sys_q};
                `CDCE_DSP_OFS:  rdat_d = {16'h0000, dsp_q};
                `CDCE_IMP_OFS:  rdat_d = {16'h0000, 3'h0, val_q, rng_q, dac_q};
                `CDCE_STAT_OFS: rdat_d = {16'h0000, 2'h0, proc_run, core_run,
                                          4'h0, proc_act, core_act};
                default:        rdat_d = 32'h0000_0000;
            endcase
        end
    end

    // bus and control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_q  <= `CDCE_SYS_RST;
            dsp_q  <= `CDCE_DSP_RST;
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            sys_q  <= sys_d;
            dsp_q  <= dsp_d;
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // configuration straight from the control flops
    assign core_clock_cfg_o      = to_cfg(sys_q);
    assign processor_clock_cfg_o = to_cfg(dsp_q);

    // impedance window, overriding the range indication
    assign in_win = (impedance_dac_value_i >= `CDCE_IMP_MIN) &&
                    (impedance_dac_value_i <= `CDCE_IMP_MAX);

    // capture a new result on each strobe
    always_comb begin
        dac_d = dac_q;
        val_d = val_q;
        rng_d = rng_q;
        if (impedance_strobe_i) begin
            dac_d = impedance_dac_value_i;
            val_d = in_win;
            // an out-of-window value suppresses the range
            rng_d = in_win ? impedance_range_indication_i : 2'h0;
        end
    end

    // impedance registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dac_q <= 10'h000;
            val_q <= 1'b0;
            rng_q <= 2'h0;
        end else begin
            dac_q <= dac_d;
            val_q <= val_d;
            rng_q <= rng_d;
        end
    end

    assign impedance_valid_o = val_q;
    assign impedance_range_o = rng_q;

    // reference synchronisers shared by both gates
    cdce_ref_sync u_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ref_i  (ref_clk_i),
        .rise_o (rise)
    );

    // core clock gate
    cdce_clk_gate u_core (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .en_i      (sys_q[`CDCE_EN_BIT]),
        .src_i     (sys_q[`CDCE_SRC_HI:`CDCE_SRC_LO]),
        .rise_i    (rise),
        .tick_o    (core_clock_o),
        .run_o     (core_run),
        .act_src_o (core_act)
    );

    // processor clock gate
    cdce_clk_gate u_proc (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .en_i      (dsp_q[`CDCE_EN_BIT]),
        .src_i     (dsp_q[`CDCE_SRC_HI:`CDCE_SRC_LO]),
        .rise_i    (rise),
        .tick_o    (processor_clock_o),
        .run_o     (proc_run),
        .act_src_o (proc_act)
    );

    // the host keeps references alive while enabled; nothing here checks it
    // and a dead reference only leaves the tick output low

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_core_en_reset: assert property (disable iff (1'b0)
        rst_i |=> !sys_q[`CDCE_EN_BIT])
        else $error("core enable not clear after reset");
    a_en_bit_write: assert property (
        (wr && wb_adr_i == `CDCE_SYS_OFS && wb_sel_i[0])
        |=> sys_q[`CDCE_EN_BIT] == $past(wb_dat_i[`CDCE_EN_BIT]))
        else $error("enable bit not taken from bit 6");
    a_sys_one_write: assert property (
        (wr && wb_adr_i == `CDCE_SYS_OFS && wb_sel_i[0] && sys_q[`CDCE_EN_BIT]
         && wb_dat_i[`CDCE_EN_BIT])
        |=> sys_q[`CDCE_EN_BIT] &&
            sys_q[3:0] == $past(wb_dat_i[3:0]))
        else $error("core source switch dropped enable");
    a_dsp_no_drop: assert property (
        (dsp_q[`CDCE_EN_BIT] && proc_run && !$changed(dsp_q))
        ##1 $changed(dsp_q[3:0]) && dsp_q[`CDCE_EN_BIT]
        |=> !proc_run [*4] ##1 proc_run)
        else $error("processor switch blanking wrong length");
    a_imp_low: assert property (
        (impedance_strobe_i && impedance_dac_value_i < 10'h0a9)
        |=> !impedance_valid_o)
        else $error("value below 169 marked valid");
    a_imp_high: assert property (
        (impedance_strobe_i && impedance_dac_value_i > 10'h3f9)
        |=> !impedance_valid_o && impedance_range_o == 2'h0)
        else $error("value above 1017 marked valid");
    a_imp_in: assert property (
        (impedance_strobe_i && impedance_dac_value_i >= 10'h0a9 &&
         impedance_dac_value_i <= 10'h3f9)
        |=> impedance_valid_o &&
            impedance_range_o == $past(impedance_range_indication_i))
        else $error("in-window value not valid");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_core_off_quiet: assert property (
        !sys_q[`CDCE_EN_BIT] |=> !core_clock_o)
        else $error("core tick while disabled");

    c_core_tick: cover property (core_run ##1 core_clock_o);
    c_proc_switch: cover property (proc_run ##1 !proc_run [*4] ##1 proc_run);
    c_imp_valid: cover property (impedance_strobe_i ##1 impedance_valid_o);

endmodule : cdce_clock_ctrl
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the core and processor clock enable control block
`timescale 1ns/1ps
`default_nettype none
`include "cdce_map.svh"
module tb;
    // clock, reset and bus signals
    logic                    clk_i;
    logic                    rst_i;
    logic                    wb_cyc_i;
    logic                    wb_stb_i;
    logic                    wb_we_i;
    logic [15:0]             wb_adr_i;
    logic [3:0]              wb_sel_i;
    logic [31:0]             wb_dat_i;
    logic [31:0]             wb_dat_o;
    logic                    wb_ack_o;
    // references and impedance inputs
    logic [5:0]              ref_clk_i;
    logic                    imp_stb;
    logic [9:0]              imp_val;
    logic [1:0]              imp_rng;
    // design outputs
    logic                    core_tick;
    logic                    proc_tick;
    cdce_pkg::cdce_clk_cfg_t core_cfg;
    cdce_pkg::cdce_clk_cfg_t proc_cfg;
    logic                    imp_valid;
    logic [1:0]              imp_range;
    // bench bookkeeping
    int                      err_total;
    int                      comparisons;
    int                      seed;
    int                      core_n;
    int                      proc_n;
    logic [31:0]             rd;
    // usable source codes in reference index order
    logic [3:0]              codes [6] = '{4'h0, 4'h1, 4'h4, 4'h7, 4'h8, 4'h9};

    cdce_clock_ctrl dut (
        .clk_i                        (clk_i),
        .rst_i                        (rst_i),
        .wb_cyc_i                     (wb_cyc_i),
        .wb_stb_i                     (wb_stb_i),
        .wb_we_i                      (wb_we_i),
        .wb_adr_i                     (wb_adr_i),
        .wb_sel_i                     (wb_sel_i),
        .wb_dat_i                     (wb_dat_i),
        .wb_dat_o                     (wb_dat_o),
        .wb_ack_o                     (wb_ack_o),
        .ref_clk_i                    (ref_clk_i),
        .impedance_strobe_i           (imp_stb),
        .impedance_dac_value_i        (imp_val),
        .impedance_range_indication_i (imp_rng),
        .core_clock_o                 (core_tick),
        .processor_clock_o            (proc_tick),
        .core_clock_cfg_o             (core_cfg),
        .processor_clock_cfg_o        (proc_cfg),
        .impedance_valid_o            (imp_valid),
        .impedance_range_o            (imp_range)
    );

    // 250 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // count gated ticks of both derived clocks
    always @(posedge clk_i) begin
        if (core_tick === 1'b1) core_n++;
        if (proc_tick === 1'b1) proc_n++;
    end

    // one comparison, reported at once on mismatch
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // classic single wishbone cycle, waits for ack under a bound
    task automatic wb(input logic we, input logic [15:0] adr, input logic [31:0] dat,
                      output logic [31:0] q);
        int n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) chk("bus ack", 32'h1, 32'h0);
        q = wb_dat_o;
        // release only after the ack edge
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb

    // read a register and compare it
    task automatic rd_chk(input logic [15:0] adr, input logic [31:0] exp, input string what);
        logic [31:0] q;
        wb(1'b0, adr, 32'h0, q);
        chk(what, exp, q);
    endtask : rd_chk

    // target gets k rises, every other reference 2k rises, all end low
    task automatic run_refs(input int tgt, input int k);
        logic [5:0] v;
        for (int i = 0; i < k; i++) begin
            for (int j = 0; j < 8; j++) begin
                @(posedge clk_i);
                for (int b = 0; b < 6; b++) v[b] = (b == tgt) ? (j < 4) : ((j % 4) < 2);
                ref_clk_i <= v;
            end
        end
    endtask : run_refs

    // expected ticks of one derived clock over a run_refs window
    function automatic int exp_ticks(input logic en, input logic [3:0] code, input int tgt,
                                     input int k);
        int idx = -1;
        for (int i = 0; i < 6; i++) if (codes[i] === code) idx = i;
        if (en !== 1'b1 || idx < 0) return 0;
        return (idx == tgt) ? k : 2 * k;
    endfunction : exp_ticks

    // one impedance sample, result checked the cycle after the strobe edge
    task automatic imp_chk(input logic [9:0] v, input logic [1:0] r);
        logic ok;
        ok = (v >= 10'h0a9) && (v <= 10'h3f9);
        @(posedge clk_i);
        imp_stb <= 1'b1;
        imp_val <= v;
        imp_rng <= r;
        @(posedge clk_i);
        imp_stb <= 1'b0;
        @(posedge clk_i);
        chk("impedance valid", {31'h0, ok}, {31'h0, imp_valid});
        chk("impedance range", {30'h0, ok ? r : 2'h0}, {30'h0, imp_range});
    endtask : imp_chk

    // verdict and end of run
    task automatic final_report();
        if (err_total == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // watchdog against a hung handshake
    initial begin
        #200000;
        err_total++;
        final_report();
    end

    // main sequence
    initial begin
        logic [31:0] ds;
        logic [31:0] dp;
        int          tgt;
        int          c0;
        int          p0;
        logic [9:0]  bnd [6] = '{10'h000, 10'h0a8, 10'h0a9, 10'h3f9, 10'h3fa, 10'h3ff};
        seed = 32'he55a06f5;
        err_total = 0;
        comparisons = 0;
        core_n = 0;
        proc_n = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, imp_stb} = 4'h0;
        wb_adr_i = 16'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        ref_clk_i = 6'h0;
        imp_val = 10'h0;
        imp_rng = 2'h0;
        rst_i = 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values of both control registers and settings
        rd_chk(`CDCE_SYS_OFS, 32'h0400, "core reg reset");
        rd_chk(`CDCE_DSP_OFS, 32'h0004, "proc reg reset");
        chk("core cfg reset", 32'h080, {23'h0, core_cfg});
        chk("proc cfg reset", 32'h004, {23'h0, proc_cfg});
        // unmapped place: write ignored, reads zero
        wb(1'b1, 16'h0104, $random(seed), rd);
        rd_chk(16'h0104, 32'h0, "unmapped read");
        // configurations, early ones all enabled so source changes happen live
        for (int it = 0; it < 14; it++) begin
            ds = $random(seed);
            dp = $random(seed);
            ds[3:0] = (it < 6) ? codes[it] : ds[3:0];
            dp[3:0] = (it < 6) ? codes[5-it] : dp[3:0];
            ds[6] = ds[6] | (it < 8);
            dp[6] = dp[6] | (it < 8);
            ref_clk_i <= 6'h0;
            wb(1'b1, `CDCE_SYS_OFS, ds, rd);
            wb(1'b1, `CDCE_DSP_OFS, dp, rd);
            chk("core cfg", {23'h0, ds[15], ds[10:8], ds[6], ds[3:0]}, {23'h0, core_cfg});
            chk("proc cfg", {23'h0, 1'b0, dp[10:8], dp[6], dp[3:0]}, {23'h0, proc_cfg});
            rd_chk(`CDCE_SYS_OFS, ds & 32'h874f, "core reg");
            rd_chk(`CDCE_DSP_OFS, dp & 32'h074f, "proc reg");
            repeat (12) @(posedge clk_i);
            wb(1'b0, `CDCE_STAT_OFS, 32'h0, rd);
            chk("status run", {30'h0, dp[6], ds[6]}, {30'h0, rd[13:12]});
            if (ds[6] && dp[6]) chk("status src", {24'h0, dp[3:0], ds[3:0]}, {24'h0, rd[7:0]});
            // tick counts from the selected reference only
            tgt = {$random(seed)} % 6;
            c0 = core_n;
            p0 = proc_n;
            run_refs(tgt, 3);
            repeat (8) @(posedge clk_i);
            chk("core ticks", exp_ticks(ds[6], ds[3:0], tgt, 3), core_n - c0);
            chk("proc ticks", exp_ticks(dp[6], dp[3:0], tgt, 3), proc_n - p0);
        end
        // impedance validity at the window edges, then random samples
        for (int i = 0; i < 12; i++) begin
            imp_chk((i < 6) ? bnd[i] : 10'($random(seed)), 2'($random(seed)));
        end
        final_report();
    end
endmodule : tb
`default_nettype wire
